// ### lcrb_pkg.sv
/*
 * lcrb_pkg: constants and types for the lane configuration register bank:
 * register offsets, reset values, field positions, detect modes and timing.
 * Assumes a single 125 MHz system clock; included by package name only.
 */
package lcrb_pkg;

  // register offsets on the serial management bus
  localparam logic [7:0] OFS_IDLE_CTRL = 8'h15;
  localparam logic [7:0] OFS_BOOST = 8'h16;
  localparam logic [7:0] OFS_SWING = 8'h17;
  localparam logic [7:0] OFS_DEEMPH = 8'h18;
  localparam logic [7:0] OFS_THRESH = 8'h19;
  localparam logic [7:0] OFS_SPARE = 8'h1a;
  localparam logic [7:0] OFS_SIGDET = 8'h1b;

  // reset values
  localparam logic [7:0] RST_IDLE_CTRL = 8'h00;
  localparam logic [7:0] RST_BOOST = 8'h2f;
  localparam logic [7:0] RST_SWING = 8'had;
  localparam logic [4:0] RST_DEEMPH_CTRL = 5'h02;
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_SIGDET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // field positions
  localparam int IDLE_MANUAL_BIT = 5;
  localparam int IDLE_FORCE_BIT = 4;
  localparam int FAR_RECEIVER_DETECT_MODE_MSB = 3;
  localparam int FAR_RECEIVER_DETECT_MODE_LSB = 2;
  localparam int SCP_BIT = 7;
  localparam int RATE_CLASS_BIT = 6;
  localparam int SWING_MSB = 2;
  localparam int DEEMPH_LVL_MSB = 2;
  localparam int TH_ASSERT_MSB = 3;
  localparam int TH_ASSERT_LSB = 2;
  localparam int TH_DEASSERT_MSB = 1;
  localparam int SIGDET_OFF_BIT = 2;
  localparam int SIGDET_ON_BIT = 1;

  // far receiver detect modes
  localparam logic [1:0] FAR_RECEIVER_DETECT_MODE_HIGHZ = 2'h0;
  localparam logic [1:0] FAR_RECEIVER_DETECT_MODE_LIMITED = 2'h1;
  localparam logic [1:0] FAR_RECEIVER_DETECT_MODE_ENDLESS = 2'h2;
  localparam logic [1:0] FAR_RECEIVER_DETECT_MODE_FORCED = 2'h3;

  // link rate code shown when the rate strap is not automatic
  localparam logic [1:0] RATE_GEN1 = 2'h0;

  // probe timing
  localparam int CLK_HZ = 125_000_000;
  localparam int PROBE_PERIOD_MS = 12;
  localparam int PROBE_WINDOW_MS = 600;
  localparam int PROBE_PERIOD_CYC = CLK_HZ / 1000 * PROBE_PERIOD_MS;
  localparam int PROBE_LIMIT = PROBE_WINDOW_MS / PROBE_PERIOD_MS;

  // bus slave address, value arbitrary
  localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h2c;

  // analog lane settings taken from the registers
  typedef struct packed {
    logic [7:0] input_boost_level;
    logic scp_enable;
    logic rate_class_gen12;
    logic [2:0] output_swing_level;
    logic [2:0] deemphasis_level;
    logic [1:0] idle_assert_th;
    logic [1:0] idle_deassert_th;
  } lcrb_lane_cfg_s;

endpackage

// ### lcrb_rx_probe_seq.sv
/*
 * lcrb_rx_probe_seq: far receiver probe sequencer for one lane.
 * Assumes probe_hit is already synchronised to clk_sys.
 */
`timescale 1ns/100ps
module lcrb_rx_probe_seq #(
  parameter int PERIOD_CYC = lcrb_pkg::PROBE_PERIOD_CYC,
  parameter int TRY_LIMIT = lcrb_pkg::PROBE_LIMIT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control and result
  input wire logic [1:0] mode,
  input wire logic probe_hit,
  // probe strobe and status
  output logic probe_pulse,
  output logic present
);

  localparam int CNT_W = $clog2(PERIOD_CYC + 1);
  localparam int TRY_W = $clog2(TRY_LIMIT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYC - 1);
  localparam logic [TRY_W-1:0] TRY_MAX = TRY_W'(TRY_LIMIT);
  localparam logic [TRY_W-1:0] TRY_ONE = TRY_W'(1);

  typedef enum logic [1:0] {ps_off, ps_wait, ps_stop} lcrb_probe_e;

  lcrb_probe_e state;
  logic [CNT_W-1:0] cnt;
  logic [TRY_W-1:0] tries;
  logic [1:0] mode_q;

  // refuse settings the counters cannot serve
  if (PERIOD_CYC < 2 || TRY_LIMIT < 1) begin : g_bad_param
    $error("lcrb_rx_probe_seq: period or try limit too small");
  end

  // probe every period until found; limited mode gives up after the limit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ps_off;
      cnt <= '0;
      tries <= '0;
      probe_pulse <= 1'b0;
      present <= 1'b0;
      mode_q <= lcrb_pkg::FAR_RECEIVER_DETECT_MODE_HIGHZ;
    end else begin
      probe_pulse <= 1'b0;
      mode_q <= mode;
      if (mode != mode_q) begin
        state <= ps_off; // restart on any mode change
        present <= 1'b0;
      end else begin
        case (state)
          ps_off: begin
            if (mode == lcrb_pkg::FAR_RECEIVER_DETECT_MODE_LIMITED ||
                mode == lcrb_pkg::FAR_RECEIVER_DETECT_MODE_ENDLESS) begin
              probe_pulse <= 1'b1;
              tries <= TRY_ONE;
              cnt <= '0;
              state <= ps_wait;
            end
          end
          ps_wait: begin
            if (probe_hit) begin
              present <= 1'b1;
              state <= ps_stop;
            end else if (cnt == CNT_LAST) begin
              cnt <= '0;
              if (mode == lcrb_pkg::FAR_RECEIVER_DETECT_MODE_LIMITED && tries == TRY_MAX) begin
                state <= ps_stop;
              end else begin
                probe_pulse <= 1'b1;
                tries <= tries + TRY_ONE;
              end
            end else begin
              cnt <= cnt + CNT_W'(1);
            end
          end
          default: begin
            state <= ps_stop; // found or gave up: hold until mode changes
          end
        endcase
      end
    end
  end

endmodule

// ### lcrb_lane_config_bank.sv
/*
 * lcrb_lane_config_bank: lane one configuration and status registers plus
 * the lane two signal detect force register, as a serial management bus
 * slave (byte write, byte read, auto increment on multi-byte transfers).
 * Assumes bus pins and analog status arrive asynchronously to clk_sys and
 * that the pad resolves the open-drain data line from smb_sda_oe.
 */
`timescale 1ns/100ps

// Function
// - manual idle bit selects forced muting; clear lets idle detect mute
// - under manual control the force bit mutes the output, zero drives it
// - detect mode 00 keeps input termination high impedance
// - mode 01 probes every 12 ms, 50 attempts, then stops if nothing found
// - mode 10 probes every 12 ms without limit until a receiver is found
// - automatic modes hold high impedance until found, then 50 ohm
// - mode 11 forces 50 ohm termination; register wins over the strap
// - eight-bit input boost register, 256 levels, reset 0x2f
// - swing register bit 7 enables short-circuit protection; reset 0xad
// - rate class bit: one picks gen 1/2, zero gen 3; overrides strap
// - three-bit swing code 000..111 gives 0.7 V..1.4 V, default 101
// - read-only bit 7 of de-emphasis register shows far receiver found
// - bits 6:5 report link rate, valid only with automatic rate strap
// - three-bit de-emphasis code 000..111, 0 to -12 dB, default 010
// - assert threshold bits 3:2 pick the level; override threshold strap
// - de-assert threshold bits 1:0 pick the level, default code 00
// - force-off bit 2 holds lane two signal detect low
// - force-on bit 1 holds lane two signal detect high while force-off bit 2 is clear
module lcrb_lane_config_bank #(
  parameter logic [6:0] SMB_ADDR = lcrb_pkg::SMB_ADDR_DEFAULT,
  parameter int PROBE_PERIOD_CYC = lcrb_pkg::PROBE_PERIOD_CYC,
  parameter int PROBE_LIMIT = lcrb_pkg::PROBE_LIMIT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // serial management bus pins
  input wire logic smb_scl_in,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe,
  // analog lane status, asynchronous
  input wire logic probe_hit_in,
  input wire logic auto_idle_in,
  input wire logic lane2_raw_sigdet_in,
  input wire logic rate_strap_auto_in,
  input wire logic [1:0] link_rate_in,
  // lane controls
  output logic lane_mute,
  output logic term_50ohm,
  output logic rx_probe,
  output logic lane2_sigdet,
  output lcrb_pkg::lcrb_lane_cfg_s lane1_cfg
);

  typedef enum logic [3:0] {
    st_idle, st_addr, st_addr_ack, st_cmd, st_cmd_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rdata_ack
  } lcrb_smb_e;

  localparam int SYNC_W = 8;
  // bus lines idle high, lane status idle low: no false mute after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {2'b11, {(SYNC_W-2){1'b0}}};

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic scl_s, sda_s, probe_hit_s, auto_idle_s, sigdet_s, strap_auto_s;
  logic [1:0] link_rate_s;
  logic scl_prev, sda_prev;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  lcrb_smb_e state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic rw_read;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  logic [7:0] idle_ctrl;
  logic [7:0] boost;
  logic [7:0] swing;
  logic [4:0] deemph_ctrl;
  logic [7:0] thresh;
  logic [7:0] sigdet_force;
  logic far_present;
  logic probe_pulse;
  logic [1:0] rate_shown;
  logic [7:0] rd_data;
  logic [1:0] far_receiver_detect_mode_mode;

  // two-flop synchroniser for every asynchronous input
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_meta <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      sync_meta <= {smb_scl_in, smb_sda_in, probe_hit_in, auto_idle_in,
                    lane2_raw_sigdet_in, rate_strap_auto_in, link_rate_in};
      sync_q <= sync_meta;
    end
  end

  assign {scl_s, sda_s, probe_hit_s, auto_idle_s, sigdet_s, strap_auto_s,
          link_rate_s} = sync_q;

  // bus line history for edge and condition detection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // clock edges, start and stop seen on the synchronised lines
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  assign bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
  assign bus_stop = scl_s & scl_prev & ~sda_prev & sda_s;

  // read multiplexer; unmapped and spare offsets read as zero
  always_comb begin
    if (ptr == lcrb_pkg::OFS_IDLE_CTRL) begin
      rd_data = idle_ctrl;
    end else if (ptr == lcrb_pkg::OFS_BOOST) begin
      rd_data = boost;
    end else if (ptr == lcrb_pkg::OFS_SWING) begin
      rd_data = swing;
    end else if (ptr == lcrb_pkg::OFS_DEEMPH) begin
      rd_data = {far_present, rate_shown, deemph_ctrl};
    end else if (ptr == lcrb_pkg::OFS_THRESH) begin
      rd_data = thresh;
    end else if (ptr == lcrb_pkg::OFS_SIGDET) begin
      rd_data = sigdet_force;
    end else begin
      rd_data = lcrb_pkg::READ_ZERO;
    end
  end

  // link rate is only meaningful with the automatic rate strap
  assign rate_shown = strap_auto_s ? link_rate_s : lcrb_pkg::RATE_GEN1;

  // bus slave: byte protocol, acknowledge and read shifting
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= st_idle;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 8'h00;
      rw_read <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      smb_sda_oe <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (bus_start) begin
        state <= st_addr; // start or repeated start keeps the pointer
        bitcnt <= 4'h0;
        smb_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= st_idle;
        smb_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          st_addr, st_cmd, st_wdata: begin
            if (bitcnt != 4'h8) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          st_rdata: begin
            bitcnt <= bitcnt + 4'h1;
          end
          st_rdata_ack: begin
            if (sda_s) begin
              state <= st_idle; // host refused more data
            end else begin
              ptr <= ptr + 8'h01;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          st_addr: begin
            if (bitcnt == 4'h8) begin
              if (shreg[7:1] == SMB_ADDR) begin
                rw_read <= shreg[0];
                state <= st_addr_ack;
                smb_sda_oe <= 1'b1;
              end else begin
                state <= st_idle;
              end
            end
          end
          st_addr_ack: begin
            bitcnt <= 4'h0;
            if (rw_read) begin
              txreg <= rd_data;
              smb_sda_oe <= ~rd_data[7];
              state <= st_rdata;
            end else begin
              smb_sda_oe <= 1'b0;
              state <= st_cmd;
            end
          end
          st_cmd: begin
            if (bitcnt == 4'h8) begin
              ptr <= shreg;
              smb_sda_oe <= 1'b1;
              state <= st_cmd_ack;
            end
          end
          st_wdata: begin
            if (bitcnt == 4'h8) begin
              wr_en <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              smb_sda_oe <= 1'b1;
              state <= st_wdata_ack;
            end
          end
          st_cmd_ack, st_wdata_ack: begin
            if (state == st_wdata_ack) begin
              ptr <= ptr + 8'h01;
            end
            smb_sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            state <= st_wdata;
          end
          st_rdata: begin
            if (bitcnt == 4'h8) begin
              smb_sda_oe <= 1'b0; // release for the host acknowledge
              state <= st_rdata_ack;
            end else begin
              smb_sda_oe <= ~txreg[3'(4'h7 - bitcnt)];
            end
          end
          st_rdata_ack: begin
            txreg <= rd_data;
            smb_sda_oe <= ~rd_data[7];
            bitcnt <= 4'h0;
            state <= st_rdata;
          end
          default: begin
            smb_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pull low
  assign smb_sda_out = 1'b0;

  // register file; values hold until reset or the next write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_ctrl <= lcrb_pkg::RST_IDLE_CTRL;
      boost <= lcrb_pkg::RST_BOOST;
      swing <= lcrb_pkg::RST_SWING;
      deemph_ctrl <= lcrb_pkg::RST_DEEMPH_CTRL;
      thresh <= lcrb_pkg::RST_THRESH;
      sigdet_force <= lcrb_pkg::RST_SIGDET;
    end else if (wr_en) begin
      if (wr_addr == lcrb_pkg::OFS_IDLE_CTRL) begin
        idle_ctrl <= wr_data;
      end else if (wr_addr == lcrb_pkg::OFS_BOOST) begin
        boost <= wr_data;
      end else if (wr_addr == lcrb_pkg::OFS_SWING) begin
        swing <= wr_data; // stored as written
      end else if (wr_addr == lcrb_pkg::OFS_DEEMPH) begin
        deemph_ctrl <= wr_data[4:0]; // status bits ignore writes
      end else if (wr_addr == lcrb_pkg::OFS_THRESH) begin
        thresh <= wr_data;
      end else if (wr_addr == lcrb_pkg::OFS_SIGDET) begin
        sigdet_force <= wr_data;
      end
    end
  end

  assign far_receiver_detect_mode_mode = idle_ctrl[lcrb_pkg::FAR_RECEIVER_DETECT_MODE_MSB:lcrb_pkg::FAR_RECEIVER_DETECT_MODE_LSB];

  // far receiver probe sequencer
  lcrb_rx_probe_seq #(
    .PERIOD_CYC(PROBE_PERIOD_CYC),
    .TRY_LIMIT(PROBE_LIMIT)
  ) u_probe (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .mode(far_receiver_detect_mode_mode),
    .probe_hit(probe_hit_s),
    .probe_pulse(probe_pulse),
    .present(far_present)
  );

  // registered lane controls
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lane_mute <= 1'b0;
      term_50ohm <= 1'b0;
      rx_probe <= 1'b0;
      lane2_sigdet <= 1'b0;
    end else begin
      rx_probe <= probe_pulse;
      if (idle_ctrl[lcrb_pkg::IDLE_MANUAL_BIT]) begin
        lane_mute <= idle_ctrl[lcrb_pkg::IDLE_FORCE_BIT];
      end else begin
        lane_mute <= auto_idle_s;
      end
      case (far_receiver_detect_mode_mode)
        lcrb_pkg::FAR_RECEIVER_DETECT_MODE_HIGHZ: term_50ohm <= 1'b0;
        lcrb_pkg::FAR_RECEIVER_DETECT_MODE_FORCED: term_50ohm <= 1'b1;
        default: term_50ohm <= far_present;
      endcase
      if (sigdet_force[lcrb_pkg::SIGDET_OFF_BIT]) begin
        lane2_sigdet <= 1'b0;
      end else if (sigdet_force[lcrb_pkg::SIGDET_ON_BIT]) begin
        lane2_sigdet <= 1'b1;
      end else begin
        lane2_sigdet <= sigdet_s;
      end
    end
  end

  // analog settings straight from register flops; straps have no say
  assign lane1_cfg.input_boost_level = boost;
  assign lane1_cfg.scp_enable = swing[lcrb_pkg::SCP_BIT];
  assign lane1_cfg.rate_class_gen12 = swing[lcrb_pkg::RATE_CLASS_BIT];
  assign lane1_cfg.output_swing_level = swing[lcrb_pkg::SWING_MSB:0];
  assign lane1_cfg.deemphasis_level =
    deemph_ctrl[lcrb_pkg::DEEMPH_LVL_MSB:0];
  assign lane1_cfg.idle_assert_th =
    thresh[lcrb_pkg::TH_ASSERT_MSB:lcrb_pkg::TH_ASSERT_LSB];
  assign lane1_cfg.idle_deassert_th =
    thresh[lcrb_pkg::TH_DEASSERT_MSB:0];

endmodule

// ### lcrb_lane_config_bank_sva.sv
/* checker: port assertions for the lane configuration bank.
   assumes it is bound to the top module from the testbench. */
`timescale 1ns/100ps
module lcrb_lane_config_bank_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // bus pins
  input wire logic smb_scl_in,
  input wire logic smb_sda_out,
  input wire logic smb_sda_oe,
  // lane status and controls
  input wire logic probe_hit_in,
  input wire logic lane_mute,
  input wire logic term_50ohm,
  input wire logic rx_probe,
  input wire logic lane2_sigdet,
  input wire lcrb_pkg::lcrb_lane_cfg_s lane1_cfg
);
  logic [7:0] hit_hist;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // recent probe answers, to explain a rise of the termination
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hit_hist <= 8'h00;
    end else begin
      hit_hist <= {hit_hist[6:0], probe_hit_in};
    end
  end

  // reset state of fields and controls
  a_reset_fields: assert property (
    $rose(resetn) |->
    lane1_cfg == {8'h2f, 1'b1, 1'b0, 3'h5, 3'h2, 4'h0})
    else $error("lane fields wrong after reset");
  a_reset_quiet: assert property ($rose(resetn) |-> !smb_sda_oe &&
    !lane_mute && !term_50ohm && !rx_probe && !lane2_sigdet)
    else $error("controls active after reset");
  // probe strobes are single cycles and stop once a receiver is found
  a_probe_single: assert property (rx_probe |=> !rx_probe)
    else $error("probe strobe longer than one cycle");
  a_probe_found: assert property (
    term_50ohm && $past(term_50ohm) |-> !rx_probe)
    else $error("probe while termination applied");
  a_term_cause: assert property ($rose(term_50ohm) |->
    (|hit_hist) || smb_sda_oe)
    else $error("termination rose without cause");
  // fields change only at a register write, which is acknowledged
  a_cfg_on_write: assert property ($changed(lane1_cfg) |-> smb_sda_oe)
    else $error("lane fields changed outside a write");
  // data line is only moved while the bus clock is low
  a_oe_rise_low: assert property ($rose(smb_sda_oe) |-> !smb_scl_in)
    else $error("data pulled while bus clock high");
  a_oe_fall_low: assert property ($fell(smb_sda_oe) |-> !smb_scl_in)
    else $error("data released while bus clock high");
  a_sda_open: assert property (!smb_sda_out)
    else $error("data pin driven high");

  // main scenarios
  c_probe: cover property (rx_probe);
  c_term: cover property ($rose(term_50ohm));
  c_mute: cover property ($rose(lane_mute));
  c_sigdet: cover property ($rose(lane2_sigdet));
endmodule

// ### lcrb_smb_host.sv
/* host model: drives the bus clock and the open-drain data line.
   assumes a pull-up and the device pulling low through dev_oe. */
`timescale 1ns/100ps
module lcrb_smb_host (
  // clock
  input wire logic clk_sys,
  // bus pins
  input wire logic dev_oe,
  output logic scl,
  output logic sda
);
  logic sda_rel = 1'b1;
  logic scl_r = 1'b1;

  // wired line: low while either side pulls
  assign sda = sda_rel & ~dev_oe;
  assign scl = scl_r;

  // one bus phase, above the four cycle minimum
  task automatic q();
    repeat (6) @(negedge clk_sys);
  endtask
  // one bit: data moves while clock low, sampled late in high phase
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    q();
    scl_r = 1'b1;
    q();
    s = sda;
    scl_r = 1'b0;
    q();
  endtask
  // a = 1 gives a start, a = 0 a stop
  task automatic cond(input logic a);
    sda_rel = a;
    q();
    scl_r = 1'b1;
    q();
    sda_rel = ~a;
    q();
    if (a) begin
      scl_r = 1'b0;
      q();
    end
  endtask
  // eight bits msb first, then a released ninth bit
  task automatic byte_io(input logic [7:0] d, output logic [7:0] s,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s[i]);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // one byte write, or a byte read ended by a nack
  task automatic xfer(input logic [6:0] a, input logic [7:0] ofs,
                      input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    logic [7:0] s;
    logic k0, k1, k2, kd;
    cond(1'b1);
    byte_io({a, 1'b0}, s, k0);
    byte_io(ofs, s, k1);
    if (wr) begin
      byte_io(wd, s, k2);
    end else begin
      cond(1'b1);
      byte_io({a, 1'b1}, s, k2);
      byte_io(8'hff, rd, kd);
    end
    cond(1'b0);
    ok = k0 & k1 & k2;
  endtask
endmodule

// ### tb_lcrb_lane_config_bank.sv
/* testbench for the lane configuration bank: registers through the
   host model, lane status driven directly. assumes package, design,
   host model and checker are compiled first. */
`timescale 1ns/100ps
module tb_lcrb_lane_config_bank;
  localparam int P = 20;
  localparam int L = 3;
  localparam logic [6:0] AD = lcrb_pkg::SMB_ADDR_DEFAULT;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic smb_scl_in, smb_sda_in, smb_sda_out, smb_sda_oe;
  logic probe_hit_in = 1'b0;
  logic auto_idle_in = 1'b0;
  logic lane2_raw_sigdet_in = 1'b0;
  logic rate_strap_auto_in = 1'b0;
  logic [1:0] link_rate_in = 2'h3;
  logic lane_mute, term_50ohm, rx_probe, lane2_sigdet;
  lcrb_pkg::lcrb_lane_cfg_s lane1_cfg;
  logic [7:0] rv [7] = '{8'h00, 8'h2f, 8'had, 8'h02, 8'h00, 8'h00, 8'h00};
  int n_fail = 0;
  int n_checks = 0;
  int n_probe = 0;

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;
  // probe strobe counter
  always @(posedge clk_sys) begin
    if (rx_probe === 1'b1) n_probe <= n_probe + 1;
  end

  lcrb_lane_config_bank #(.PROBE_PERIOD_CYC(P), .PROBE_LIMIT(L)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .smb_scl_in(smb_scl_in),
    .smb_sda_in(smb_sda_in), .smb_sda_out(smb_sda_out),
    .smb_sda_oe(smb_sda_oe), .probe_hit_in(probe_hit_in),
    .auto_idle_in(auto_idle_in), .lane2_raw_sigdet_in(lane2_raw_sigdet_in),
    .rate_strap_auto_in(rate_strap_auto_in), .link_rate_in(link_rate_in),
    .lane_mute(lane_mute), .term_50ohm(term_50ohm), .rx_probe(rx_probe),
    .lane2_sigdet(lane2_sigdet), .lane1_cfg(lane1_cfg));
  lcrb_smb_host host_u (.clk_sys(clk_sys), .dev_oe(smb_sda_oe),
    .scl(smb_scl_in), .sda(smb_sda_in));

  // compare and count
  task automatic chk(input string n, input logic [19:0] seen,
                     input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // register write, every byte acknowledged
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] x;
    logic ok;
    host_u.xfer(AD, ofs, 1'b1, d, x, ok);
    chk("write ack", ok, 1'b1);
  endtask
  // register read against an expected byte
  task automatic rdc(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] x;
    logic ok;
    host_u.xfer(AD, ofs, 1'b0, 8'h00, x, ok);
    chk("read ack", ok, 1'b1);
    chk("read data", x, e);
  endtask

  // main sequence
  initial begin
    logic [7:0] x;
    logic ok;
    int w;
    int p0;
    cyc(12);
    resetn = 1'b1;
    cyc(4);
    chk("cfg reset", lane1_cfg,
        {8'h2f, 1'b1, 1'b0, 3'h5, 3'h2, 4'h0});
    for (int i = 0; i < 7; i++) begin
      rdc(8'h15 + i[7:0], rv[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(lcrb_pkg::OFS_SWING, {i[0], ~i[0], 3'b101, i[2:0]});
      wr(lcrb_pkg::OFS_DEEMPH, {3'b111, 2'b00, i[2:0]});
      wr(lcrb_pkg::OFS_THRESH, {4'h0, i[1:0], ~i[1:0]});
      chk("cfg", lane1_cfg, {8'h2f, i[0], ~i[0], i[2:0], i[2:0],
          i[1:0], ~i[1:0]});
      rdc(lcrb_pkg::OFS_DEEMPH, {5'h00, i[2:0]});
    end
    wr(lcrb_pkg::OFS_BOOST, 8'hc3);
    rdc(lcrb_pkg::OFS_BOOST, 8'hc3);
    rdc(lcrb_pkg::OFS_SWING, 8'haf);
    wr(lcrb_pkg::OFS_SPARE, 8'hff);
    rdc(lcrb_pkg::OFS_SPARE, 8'h00);
    host_u.xfer(AD ^ 7'h01, lcrb_pkg::OFS_BOOST, 1'b1, 8'h00, x, ok);
    chk("foreign address", ok, 1'b0);
    rdc(lcrb_pkg::OFS_BOOST, 8'hc3);
    for (int k = 0; k < 4; k++) begin
      wr(lcrb_pkg::OFS_SIGDET, {5'h00, k[1:0], 1'b0});
      for (int r = 0; r < 2; r++) begin
        lane2_raw_sigdet_in = r[0];
        cyc(6);
        chk("sigdet", lane2_sigdet, k[1] ? 1'b0 : k[0] | r[0]);
      end
    end
    auto_idle_in = 1'b1;
    cyc(8);
    chk("mute auto", lane_mute, 1'b1);
    auto_idle_in = 1'b0;
    wr(lcrb_pkg::OFS_IDLE_CTRL, 8'h30);
    chk("mute forced", lane_mute, 1'b1);
    auto_idle_in = 1'b1;
    wr(lcrb_pkg::OFS_IDLE_CTRL, 8'h20);
    chk("mute off", lane_mute, 1'b0);
    p0 = n_probe;
    cyc(P * 4);
    chk("probes mode 0", n_probe - p0, 0);
    chk("term mode 0", term_50ohm, 1'b0);
    p0 = n_probe;
    wr(lcrb_pkg::OFS_IDLE_CTRL, 8'h04);
    cyc(P * (L + 2));
    chk("probes mode 1", n_probe - p0, L);
    chk("term mode 1", term_50ohm, 1'b0);
    p0 = n_probe;
    wr(lcrb_pkg::OFS_IDLE_CTRL, 8'h08);
    cyc(P * 4);
    chk("probes mode 2", n_probe - p0 > L, 1'b1);
    probe_hit_in = 1'b1;
    for (w = 0; w < 20 && term_50ohm !== 1'b1; w++) cyc(1);
    chk("term found", term_50ohm, 1'b1);
    if (term_50ohm !== 1'b1) finish_test();
    probe_hit_in = 1'b0;
    rate_strap_auto_in = 1'b1;
    link_rate_in = 2'h1;
    p0 = n_probe;
    rdc(lcrb_pkg::OFS_DEEMPH, 8'ha7);
    chk("probes after find", n_probe - p0, 0);
    wr(lcrb_pkg::OFS_IDLE_CTRL, 8'h0c);
    cyc(4);
    chk("term forced", term_50ohm, 1'b1);
    rdc(lcrb_pkg::OFS_DEEMPH, 8'h27);
    finish_test();
  end
endmodule

bind lcrb_lane_config_bank lcrb_lane_config_bank_sva chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .smb_scl_in(smb_scl_in),
  .smb_sda_out(smb_sda_out), .smb_sda_oe(smb_sda_oe),
  .probe_hit_in(probe_hit_in), .lane_mute(lane_mute),
  .term_50ohm(term_50ohm), .rx_probe(rx_probe),
  .lane2_sigdet(lane2_sigdet), .lane1_cfg(lane1_cfg));
